/* ftsdp_regs.svh */
// Constants of the flow-through SRAM data port: widths, reset values, counts.
// Assumes it is included by its bare name by the package and the modules.
`ifndef FTSDP_REGS_SVH
`define FTSDP_REGS_SVH

`define FTSDP_ADDR_W 19
`define FTSDP_DATA_W 32
`define FTSDP_PAR_W 4
`define FTSDP_CLK_PERIOD_NS 10
`define FTSDP_BURST_START 2'h0
`define FTSDP_BURST_STEP 2'h1
`define FTSDP_STRAP_WAIT 2'h3
`define FTSDP_OE_N_RST 1'h1
`define FTSDP_SLEEP_RST 1'h0
`define FTSDP_STRAP_RST 1'h0
`define FTSDP_ORDER_RST 1'h1

`endif

/* ftsdp_pkg.sv */
// Types and the burst order function of the flow-through SRAM data port.
// Assumes ftsdp_regs.svh sits in the same folder.
`include "ftsdp_regs.svh"

package ftsdp_pkg;

    // Kind of the cycle whose data phase is under way
    typedef enum logic [1:0]
    {
        FTSDP_DESEL,
        FTSDP_READ,
        FTSDP_WRITE
    } ftsdp_cycle_t;

    // Low two address bits of a burst beat
    function automatic logic [1:0] ftsdp_burst_low(input logic [1:0] start,
                                                   input logic [1:0] cnt,
                                                   input logic interleave);
        logic [1:0] res;
        res = interleave ? (start ^ cnt) : 2'(start + cnt);
        return res;
    endfunction : ftsdp_burst_low

endpackage : ftsdp_pkg

/* ftsdp_sync2.sv */
// Two-stage synchroniser for a level that arrives from outside the clock.
// Assumes the level stays put long enough to be seen on two edges.
module ftsdp_sync2
    import ftsdp_pkg::*;
#(
    parameter logic RST_VAL = 1'h0
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);

    logic meta_ff;
    logic sync_ff;

    // First stage feeds only the second one
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : ftsdp_sync2

/* ftsdp_burst_gen.sv */
// Burst address generator: start address plus a two-bit beat counter.
// Assumes the caller qualifies every step with its own edge enable.
`include "ftsdp_regs.svh"

module ftsdp_burst_gen
    import ftsdp_pkg::*;
#(
    parameter int ADDR_W = `FTSDP_ADDR_W
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic step_en_i,
    input wire logic load_i,
    input wire logic advance_i,
    input wire logic interleave_i,
    input wire logic [ADDR_W-1:0] start_addr_i,
    output logic [ADDR_W-1:0] nxt_addr_o,
    output logic [ADDR_W-1:0] cur_addr_o
);

    logic [ADDR_W-1:0] base_ff;
    logic [1:0] cnt_ff;
    logic [ADDR_W-1:0] nxt_base;
    logic [1:0] nxt_cnt;
    logic [1:0] adv_cnt;

    // Counter wraps at four, so a burst loops inside its aligned group
    assign adv_cnt = 2'(cnt_ff + `FTSDP_BURST_STEP);
    assign nxt_cnt = load_i ? `FTSDP_BURST_START : (advance_i ? adv_cnt : cnt_ff);
    assign nxt_base = load_i ? start_addr_i : base_ff;
    assign nxt_addr_o = {nxt_base[ADDR_W-1:2],
                         ftsdp_burst_low(nxt_base[1:0], nxt_cnt, interleave_i)};
    assign cur_addr_o = {base_ff[ADDR_W-1:2],
                         ftsdp_burst_low(base_ff[1:0], cnt_ff, interleave_i)};

    // Start and count move only on taken edges
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            base_ff <= '0;
            cnt_ff <= `FTSDP_BURST_START;
        end
        else if (step_en_i)
        begin
            base_ff <= nxt_base;
            cnt_ff <= nxt_cnt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    linear_step_a: assert property ((step_en_i && load_i) ##1
        (step_en_i && advance_i && !load_i && !interleave_i)
        |=> cur_addr_o[1:0] == 2'($past(cur_addr_o[1:0]) + 2'h1))
        else $error("linear burst did not add one");
    interleave_step_a: assert property ((step_en_i && load_i) ##1
        (step_en_i && advance_i && !load_i && interleave_i)
        |=> cur_addr_o[1:0] == ($past(cur_addr_o[1:0]) ^ 2'h1))
        else $error("interleaved burst did not flip bit zero");
    burst_upper_a: assert property ((step_en_i && !load_i)
        |=> $stable(cur_addr_o[ADDR_W-1:2]))
        else $error("burst changed upper address bits");

endmodule : ftsdp_burst_gen

/* ftsdp_flow_sram.sv */
// Flow-through burst SRAM data port: clock gate, sleep, array, data drivers.
// Assumes a controller on the same clock; output enable, sleep and the
// burst strap are pins from elsewhere and are synchronised here.
`include "ftsdp_regs.svh"

module ftsdp_flow_sram
    import ftsdp_pkg::*;
#(
    parameter int ADDR_W = `FTSDP_ADDR_W,
    parameter int DATA_W = `FTSDP_DATA_W,
    parameter int PAR_W = `FTSDP_PAR_W
)
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CLOCK_GATE_N_I,
    input wire logic SELECT_I,
    input wire logic ADVANCE_I,
    input wire logic WRITE_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] DQ_I,
    input wire logic [PAR_W-1:0] PARITY_LINES_I,
    input wire logic OUT_EN_N_I,
    input wire logic SLEEP_REQUEST_I,
    input wire logic BURST_MODE_I,
    output logic [DATA_W-1:0] DQ_O,
    output logic DQ_OE_O,
    output logic [PAR_W-1:0] PARITY_LINES_O,
    output logic PARITY_LINES_OE_O,
    output logic SLEEP_O
);

    localparam int WORD_W = DATA_W + PAR_W;
    localparam int DEPTH = 2 ** ADDR_W;

    // Array words hold parity above data, one lane bit per byte
    logic [WORD_W-1:0] mem [DEPTH];

    // Cycle kind and the drive bookkeeping that follows it
    ftsdp_cycle_t state_ff;
    ftsdp_cycle_t nxt_state;
    logic first_ff;
    logic nxt_first;
    logic drive_ff;
    logic nxt_drive;
    logic oe_ff;

    // Read word, write data register and pin-side flags
    logic [WORD_W-1:0] word_ff;
    logic [WORD_W-1:0] din_ff;
    logic sleep_ff;
    logic order_ff;
    logic [1:0] strap_cnt_ff;

    // Pins after their synchronisers
    logic oe_n_s;
    logic sleep_s;
    logic strap_s;

    // Edge qualification and the address and data paths
    logic edge_en;
    logic new_cmd;
    logic keep_burst;
    logic drive_hold;
    logic bypass;
    logic [ADDR_W-1:0] nxt_addr;
    logic [ADDR_W-1:0] cur_addr;
    logic [WORD_W-1:0] bus_word;
    logic [WORD_W-1:0] rd_word;
    logic wr_take;

    // Pins from outside the clock pass two flip-flops first
    // Reset values keep drivers off and sleep low until the pins are seen
    ftsdp_sync2 #(.RST_VAL(`FTSDP_OE_N_RST)) u_oe_sync
    (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(OUT_EN_N_I),
        .sync_o(oe_n_s)
    );

    ftsdp_sync2 #(.RST_VAL(`FTSDP_SLEEP_RST)) u_sleep_sync
    (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(SLEEP_REQUEST_I),
        .sync_o(sleep_s)
    );

    ftsdp_sync2 #(.RST_VAL(`FTSDP_STRAP_RST)) u_strap_sync
    (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(BURST_MODE_I),
        .sync_o(strap_s)
    );

    // An edge counts only with the gate low and no sleep pending
    assign edge_en = !CLOCK_GATE_N_I && !sleep_s;
    assign new_cmd = !ADVANCE_I && SELECT_I;
    assign keep_burst = ADVANCE_I && (state_ff != FTSDP_DESEL);

    ftsdp_burst_gen #(.ADDR_W(ADDR_W)) u_burst
    (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .step_en_i(edge_en),
        .load_i(new_cmd),
        .advance_i(keep_burst),
        .interleave_i(order_ff),
        .start_addr_i(ADDR_I),
        .nxt_addr_o(nxt_addr),
        .cur_addr_o(cur_addr)
    );

    // Next cycle kind; an advance after deselect stays deselected
    // Advance outranks select, so a stray select cannot break a burst
    always_comb
    begin
        nxt_state = state_ff;
        case ({ADVANCE_I, SELECT_I})
            2'h2, 2'h3: nxt_state = state_ff;
            2'h1: nxt_state = WRITE_I ? FTSDP_WRITE : FTSDP_READ;
            default: nxt_state = FTSDP_DESEL;
        endcase
    end

    // Drive is allowed only for a read that is not the first out of deselect
    assign nxt_first = (state_ff == FTSDP_DESEL) && (nxt_state != FTSDP_DESEL);
    assign nxt_drive = (nxt_state == FTSDP_READ) && !nxt_first;
    assign drive_hold = edge_en ? nxt_drive : drive_ff;

    // Read just after a write to the same word takes the bus value, so no dead cycle
    assign bus_word = {PARITY_LINES_I, DQ_I};
    assign wr_take = edge_en && (state_ff == FTSDP_WRITE);
    assign bypass = wr_take && (cur_addr == nxt_addr);
    assign rd_word = bypass ? bus_word : mem[nxt_addr];

    // Cycle state moves only on taken edges; gating never deselects
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_ff <= FTSDP_DESEL;
            first_ff <= 1'b0;
            drive_ff <= 1'b0;
        end
        else if (edge_en)
        begin
            state_ff <= nxt_state;
            first_ff <= nxt_first;
            drive_ff <= nxt_drive;
        end
    end

    // Flow-through: the word leaves on the edge that takes its address
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            word_ff <= '0;
        end
        else if (edge_en && nxt_state == FTSDP_READ)
        begin
            word_ff <= rd_word;
        end
    end

    // Write data register takes the lines on the data-phase edge
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            din_ff <= '0;
        end
        else if (wr_take)
        begin
            din_ff <= bus_word;
        end
    end

    // Array has no reset; contents survive sleep since nothing writes then
    always_ff @(posedge CLK_I)
    begin
        if (wr_take)
        begin
            mem[cur_addr] <= bus_word;
        end
    end

    // Output enable acts every edge, even while the clock gate holds state
    // Registering it costs latency on the pin but keeps the ports glitch free
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            oe_ff <= 1'b0;
            sleep_ff <= `FTSDP_SLEEP_RST;
        end
        else
        begin
            oe_ff <= drive_hold && !oe_n_s && !sleep_s;
            sleep_ff <= sleep_s;
        end
    end

    // Strap read on the first three edges after reset; the third, past the synchroniser, is kept
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            strap_cnt_ff <= 2'h0;
            order_ff <= `FTSDP_ORDER_RST;
        end
        else if (strap_cnt_ff != `FTSDP_STRAP_WAIT)
        begin
            strap_cnt_ff <= 2'(strap_cnt_ff + 2'h1);
            order_ff <= strap_s;
        end
    end

    // Ports come straight from flip-flops; parity shares the data enable
    assign DQ_O = word_ff[DATA_W-1:0];
    assign PARITY_LINES_O = word_ff[WORD_W-1:DATA_W];
    assign DQ_OE_O = oe_ff;
    assign PARITY_LINES_OE_O = oe_ff;
    assign SLEEP_O = sleep_ff;

    // Checks sample on the rising edge and stay quiet through reset
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Checks of gating, drivers and data
    gate_hold_a: assert property ((CLOCK_GATE_N_I && !sleep_s)
        |=> $stable(state_ff) && $stable(word_ff) && $stable(cur_addr))
        else $error("state moved while clock gate was high");
    gate_keeps_sel_a: assert property ((state_ff != FTSDP_DESEL)
        ##0 CLOCK_GATE_N_I [*2] |=> state_ff != FTSDP_DESEL)
        else $error("clock gate deselected the device");
    normal_cycle_a: assert property ((edge_en && !ADVANCE_I && !SELECT_I)
        |=> state_ff == FTSDP_DESEL)
        else $error("enabled edge did not take a deselect");
    sleep_hold_a: assert property (sleep_s
        |=> !DQ_OE_O && SLEEP_O && $stable(state_ff))
        else $error("sleep did not hold state or drivers stayed on");
    write_capture_a: assert property (wr_take
        |=> din_ff == $past(bus_word))
        else $error("write data register missed the lines");
    read_bypass_a: assert property ((bypass && nxt_state == FTSDP_READ)
        |=> word_ff == $past(bus_word))
        else $error("read after write lost the new word");
    oe_drive_a: assert property ((edge_en && nxt_drive && !oe_n_s && !sleep_s)
        |=> DQ_OE_O && PARITY_LINES_OE_O)
        else $error("read with output enable low not driven");
    oe_off_a: assert property (oe_n_s [*2] |=> !DQ_OE_O && !PARITY_LINES_OE_O)
        else $error("drivers on with output enable high");
    write_off_a: assert property ((state_ff == FTSDP_WRITE) |-> !DQ_OE_O)
        else $error("drivers on in a write data cycle");
    first_off_a: assert property ((state_ff == FTSDP_DESEL) ##1
        (state_ff != FTSDP_DESEL && first_ff) |-> !DQ_OE_O)
        else $error("drivers on first clock out of deselect");
    desel_off_a: assert property ((state_ff == FTSDP_DESEL) |-> !DQ_OE_O)
        else $error("drivers on while deselected");
    parity_same_a: assert property (DQ_OE_O == PARITY_LINES_OE_O)
        else $error("parity drive differs from data drive");

    // Drivers, array and pin flags seen from the ports
    drive_read_only_a: assert property (DQ_OE_O
        |-> (state_ff == FTSDP_READ) && !first_ff && !SLEEP_O)
        else $error("drivers on outside a settled read");
    gate_drive_a: assert property ((CLOCK_GATE_N_I && drive_ff && !oe_n_s && !sleep_s)
        |=> DQ_OE_O && PARITY_LINES_OE_O)
        else $error("held read lost its drivers under the clock gate");
    first_load_a: assert property ((edge_en && nxt_first)
        |=> first_ff && !DQ_OE_O && !PARITY_LINES_OE_O)
        else $error("first cycle out of deselect was driven");
    advance_idle_a: assert property ((edge_en && ADVANCE_I && state_ff == FTSDP_DESEL)
        |=> state_ff == FTSDP_DESEL && !DQ_OE_O)
        else $error("advance while deselected selected the device");
    read_word_a: assert property ((edge_en && nxt_state == FTSDP_READ && !bypass)
        |=> {PARITY_LINES_O, DQ_O} == mem[$past(nxt_addr)])
        else $error("read word differs from the array word");
    write_store_a: assert property (wr_take
        |=> mem[$past(cur_addr)] == $past(bus_word))
        else $error("write data did not reach the array");
    din_hold_a: assert property (!wr_take |=> $stable(din_ff))
        else $error("write data register moved outside a data phase");
    burst_beat_a: assert property ((edge_en && keep_burst)
        |=> $stable(cur_addr[ADDR_W-1:2]))
        else $error("burst beat left its aligned group");
    strap_once_a: assert property ((strap_cnt_ff == `FTSDP_STRAP_WAIT)
        |=> $stable(order_ff) && $stable(strap_cnt_ff))
        else $error("burst order changed after the strap was read");
    sleep_release_a: assert property ($fell(sleep_s) |=> !SLEEP_O)
        else $error("sleep flag stayed up after the request dropped");

    // Main scenarios
    write_then_read_c: cover property (wr_take ##1 (state_ff == FTSDP_READ && DQ_OE_O));
    burst_read_c: cover property ((edge_en && keep_burst && state_ff == FTSDP_READ) [*3]);
    gate_stretch_c: cover property ((state_ff == FTSDP_READ) ##1 CLOCK_GATE_N_I [*3]);
    sleep_wake_c: cover property (SLEEP_O ##1 !SLEEP_O ##[1:8] DQ_OE_O);
    bypass_read_c: cover property (bypass && nxt_state == FTSDP_READ);

endmodule : ftsdp_flow_sram

/* ftsdp_ctl_model.sv */
// Far-side controller model: resolves the shared data and parity wire.
// Assumes the bench raises the controller drive only in write data phases.
module ftsdp_ctl_model
#(
    parameter int W = 36
)
(
    input wire logic clk_i,
    input wire logic dq_oe_i,
    input wire logic par_oe_i,
    input wire logic [W-1:0] dev_word_i,
    input wire logic ctl_oe_i,
    input wire logic [W-1:0] ctl_word_i,
    output logic [W-1:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [W-1:0] last_ff;
    logic [W-1:0] dev_en;

    // Parity lanes sit in the top four bits
    assign dev_en = {{4{par_oe_i}}, {(W-4){dq_oe_i}}};

    // Two drivers on a lane show as unknown; an undriven lane flips each
    // cycle, so a stale value can never pass for good data
    always_comb
    begin
        for (int b = 0; b < W; b++)
            if (dev_en[b] && ctl_oe_i)
                wire_o[b] = 1'bx;
            else if (dev_en[b])
                wire_o[b] = dev_word_i[b];
            else if (ctl_oe_i)
                wire_o[b] = ctl_word_i[b];
            else
                wire_o[b] = ~last_ff[b];
    end

    // Remember the wire so the floating value keeps moving
    always_ff @(posedge clk_i)
        last_ff <= wire_o;
endmodule : ftsdp_ctl_model

/* ftsdp_tb.sv */
// Self-checking bench of the flow-through SRAM data port.
// Assumes the controller model drives the wire; checks sit one edge later.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int AW = 4;
    localparam int TIME_LIMIT = 1000;
    logic clk, rst_n, gate_n, sel, adv, wr, oe_n, sleep_req, mode, ctl_oe;
    logic [AW-1:0] addr;
    logic [35:0] ctl_word, bus;
    logic [31:0] dq_o;
    logic [3:0] par_o;
    logic dq_oe, par_oe, sleep_o;
    int err_count, total_checks, cycles;

    ftsdp_flow_sram #(.ADDR_W(AW)) DUT (.CLK_I(clk), .RST_N_I(rst_n), .CLOCK_GATE_N_I(gate_n),
        .SELECT_I(sel), .ADVANCE_I(adv), .WRITE_I(wr), .ADDR_I(addr), .DQ_I(bus[31:0]),
        .PARITY_LINES_I(bus[35:32]), .OUT_EN_N_I(oe_n), .SLEEP_REQUEST_I(sleep_req),
        .BURST_MODE_I(mode), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .PARITY_LINES_O(par_o),
        .PARITY_LINES_OE_O(par_oe), .SLEEP_O(sleep_o));
    ftsdp_ctl_model far (.clk_i(clk), .dq_oe_i(dq_oe), .par_oe_i(par_oe),
        .dev_word_i({par_o, dq_o}), .ctl_oe_i(ctl_oe), .ctl_word_i(ctl_word), .wire_o(bus));

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == TIME_LIMIT)
        begin
            err_count++;
            print_verdict();
        end
    end

    // Test word stored at address i
    function automatic logic [35:0] wd(input int i);
        return {4'(i + 1), 32'hC0DE0000 + 32'(i)};
    endfunction : wd

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic chk_word(input string what, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // Data and parity drivers always move together
    task automatic chk_oe(input logic exp);
        chk_bit("data drive", exp, dq_oe);
        chk_bit("parity drive", exp, par_oe);
    endtask : chk_oe

    // One cycle of controller stimulus; outputs are settled on return
    task automatic cmd(input logic g, s, a, w, input int ad, input logic d, input logic [35:0] dw);
        @(posedge clk);
        gate_n <= g;
        sel <= s;
        adv <= a;
        wr <= w;
        addr <= AW'(ad);
        ctl_oe <= d;
        ctl_word <= dw;
        #1;
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) cmd(1'b0, 1'b0, 1'b0, 1'b0, 0, 1'b0, '0);
    endtask : idle

    // Strap is read only after reset, so each burst order gets its own reset
    task automatic do_reset(input logic m);
        @(posedge clk);
        rst_n <= 1'b0;
        mode <= m;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        idle(4);
    endtask : do_reset

    // Back-to-back writes, a read of the last one right behind them, then a burst
    task automatic t_burst(input logic m);
        for (int i = 0; i < 5; i++)
        begin
            cmd(1'b0, 1'b1, 1'b0, i < 4, (i < 4) ? i : 3, i > 0, wd(i - 1));
            if (i > 0)
                chk_oe(1'b0);
        end
        for (int k = 0; k < 4; k++)
        begin
            cmd(1'b0, 1'b0, k < 3, 1'b0, 0, 1'b0, '0);
            chk_word("burst word", wd(m ? (3 ^ k) : ((3 + k) % 4)), {par_o, dq_o});
            chk_oe(1'b1);
        end
        idle(1);
        chk_oe(1'b0);
    endtask : t_burst

    // Gate held high while a deselect is presented: nothing may change
    task automatic t_gate();
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 2, 1'b0, '0);
        cmd(1'b0, 1'b0, 1'b1, 1'b0, 0, 1'b0, '0);
        chk_oe(1'b0);
        chk_word("first word", wd(2), {par_o, dq_o});
        cmd(1'b0, 1'b0, 1'b1, 1'b0, 0, 1'b0, '0);
        for (int i = 0; i < 3; i++)
        begin
            cmd(1'b1, 1'b0, 1'b0, 1'b0, 0, 1'b0, '0);
            chk_word("held word", wd(0), {par_o, dq_o});
            chk_oe(1'b1);
        end
        cmd(1'b0, 1'b0, 1'b1, 1'b0, 0, 1'b0, '0);
        cmd(1'b0, 1'b0, 1'b0, 1'b0, 0, 1'b0, '0);
        chk_word("after gate", wd(1), {par_o, dq_o});
        chk_oe(1'b1);
        idle(1);
    endtask : t_gate

    // Output enable pin high during a read burst
    task automatic t_oe();
        @(posedge clk);
        oe_n <= 1'b1;
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 0, 1'b0, '0);
        cmd(1'b0, 1'b0, 1'b1, 1'b0, 0, 1'b0, '0);
        for (int i = 0; i < 2; i++)
        begin
            cmd(1'b0, 1'b0, 1'b1, 1'b0, 0, 1'b0, '0);
            chk_oe(1'b0);
        end
        @(posedge clk);
        oe_n <= 1'b0;
        idle(4);
    endtask : t_oe

    // A write offered during sleep must leave the array alone
    task automatic t_sleep();
        @(posedge clk);
        sleep_req <= 1'b1;
        idle(3);
        chk_bit("sleep flag", 1'b1, sleep_o);
        cmd(1'b0, 1'b1, 1'b0, 1'b1, 1, 1'b0, '0);
        cmd(1'b0, 1'b0, 1'b0, 1'b0, 0, 1'b1, 36'hFFFFFFFFF);
        chk_oe(1'b0);
        @(posedge clk);
        sleep_req <= 1'b0;
        idle(4);
        chk_bit("sleep flag", 1'b0, sleep_o);
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 1, 1'b0, '0);
        cmd(1'b0, 1'b0, 1'b0, 1'b0, 0, 1'b0, '0);
        chk_word("kept word", wd(1), {par_o, dq_o});
        idle(1);
    endtask : t_sleep

    // Main sequence: linear order first, then interleaved
    initial
    begin
        rst_n = 1'b0;
        gate_n = 1'b0;
        sel = 1'b0;
        adv = 1'b0;
        wr = 1'b0;
        addr = '0;
        oe_n = 1'b0;
        sleep_req = 1'b0;
        mode = 1'b0;
        ctl_oe = 1'b0;
        ctl_word = '0;
        do_reset(1'b0);
        t_burst(1'b0);
        t_gate();
        t_oe();
        t_sleep();
        do_reset(1'b1);
        t_burst(1'b1);
        t_gate();
        print_verdict();
    end
endmodule : tb
